// [hdl/spf_pin_select.sv]
// pin function select registers and pin mux for serial ports three and four
`timescale 1ns/1ps
module spf_pin_select
  import spf_pkg::*;
(
  input  wire logic        clk,                   // 125 MHz core clock
  input  wire logic        rst,                   // standby power-on reset
  input  wire logic        cfg_mode,              // device is in configuration state
  input  wire logic        idx_wr,                // write strobe to index register
  input  wire logic        data_wr,               // write strobe to data register
  input  wire logic        data_rd,               // read strobe to data register
  input  wire logic [7:0]  cfg_wdata,             // write data for index or data
  output logic      [7:0]  config_index_register, // current index
  output logic      [7:0]  cfg_rdata,             // read data
  output logic             cfg_rvalid,            // read data valid, one cycle
  output logic      [7:0]  port3_modem_line_select_a,
  output logic      [7:0]  port3_modem_line_select_b,
  output logic      [7:0]  port4_modem_line_select_a,
  input  wire logic [11:0] pin_in,                // pad levels, gpio_pin_30..41
  output logic      [11:0] pin_out,               // pad output value
  output logic      [11:0] pin_oe,                // pad drive enable, high drives
  input  wire logic [11:0] gpio_out,              // gpio block output values
  input  wire logic [11:0] gpio_oe,               // gpio block drive enables
  output logic      [11:0] gpio_in,               // synchronised pad levels
  input  wire logic        port3_transmit_data,
  input  wire logic        port3_request_send,
  input  wire logic        port3_terminal_ready,
  input  wire logic        port4_transmit_data,
  output logic             port3_ring_indicate,
  output logic             port3_carrier_detect,
  output logic             port3_receive_data,
  output logic             port3_set_ready,
  output logic             port3_clear_send,
  output logic             port4_ring_indicate,
  output logic             port4_carrier_detect,
  output logic             port4_receive_data
);

  logic [7:0]  idx_reg;            // configuration index
  logic [7:0]  sel_reg [NUM_REGS]; // select registers a, b, c
  logic [7:0]  rdata_reg;          // registered read data
  logic        rvalid_reg;         // read answer pulse
  logic [11:0] sync1_reg;          // first synchroniser stage
  logic [11:0] sync2_reg;          // second stage, the only one read
  logic [11:0] alt_sel;            // field holds the alternate code
  logic [11:0] alt_out;            // serial outputs laid out by pin
  logic [11:0] pin_out_reg;        // pad value flops
  logic [11:0] pin_oe_reg;         // pad enable flops
  logic [11:0] alt_in_reg;         // routed modem inputs by pin
  logic        wr_ok;              // data write taken this cycle
  logic        rd_ok;              // data read taken this cycle

  // accesses only count inside the configuration state
  assign wr_ok = data_wr && cfg_mode;
  assign rd_ok = data_rd && cfg_mode;

  // index register, written only in configuration state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_reg <= IDX_RESET;
    end else if (idx_wr && cfg_mode) begin
      idx_reg <= cfg_wdata;
    end
  end

  // select registers; each answers only at its own index
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int r = 0; r < NUM_REGS; r++) begin
        sel_reg[r] <= SEL_RESET;
      end
    end else if (wr_ok) begin
      unique case (idx_reg)
        IDX_SEL_A: sel_reg[0] <= cfg_wdata;
        IDX_SEL_B: sel_reg[1] <= cfg_wdata;
        IDX_SEL_C: sel_reg[2] <= cfg_wdata;
        default: ; // reserved slot and foreign indices ignore writes
      endcase
    end
  end

  // read path: one cycle latency, foreign indices read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (rd_ok) begin
      unique case (idx_reg)
        IDX_SEL_A: rdata_reg <= sel_reg[0];
        IDX_SEL_B: rdata_reg <= sel_reg[1];
        IDX_SEL_C: rdata_reg <= sel_reg[2];
        IDX_RSVD:  rdata_reg <= RSVD_VALUE;
        default:   rdata_reg <= 8'h00;     // not this block's register
      endcase
    end
  end

  // read answer strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= rd_ok;
    end
  end

  // pad inputs come from outside; two flops before any use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 12'hFFF;
      sync2_reg <= 12'hFFF;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // serial outputs placed at their pins; input-only slots tie low
  assign alt_out = {port4_transmit_data, 3'h0,
                    port3_terminal_ready, 1'b0, port3_request_send, 1'b0,
                    port3_transmit_data, 3'h0};

  // per-pin decode and mux
  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_pin
      // only code 01 selects the port; 10 and 11 fall back to gpio
      assign alt_sel[p] = sel_reg[p / FIELDS_PER][(p % FIELDS_PER) * FIELD_W +: FIELD_W]
                          == FN_ALT;

      // pad drive: serial output, released for serial input, else gpio
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pin_out_reg[p] <= 1'b0;
          pin_oe_reg[p]  <= 1'b0;
        end else if (alt_sel[p] && ALT_IS_OUT[p]) begin
          pin_out_reg[p] <= alt_out[p];
          pin_oe_reg[p]  <= 1'b1;
        end else if (alt_sel[p]) begin
          pin_out_reg[p] <= 1'b0;       // modem input: pad is listened to
          pin_oe_reg[p]  <= 1'b0;
        end else begin
          pin_out_reg[p] <= gpio_out[p];
          pin_oe_reg[p]  <= gpio_oe[p];
        end
      end

      // modem inputs see the pad only when routed, else stay idle
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          alt_in_reg[p] <= ALT_IDLE;
        end else begin
          alt_in_reg[p] <= (alt_sel[p] && !ALT_IS_OUT[p]) ? sync2_reg[p] : ALT_IDLE;
        end
      end
    end
  endgenerate

  // outputs; gpio always sees the pad so its input readback keeps working
  assign config_index_register     = idx_reg;
  assign cfg_rdata                 = rdata_reg;
  assign cfg_rvalid                = rvalid_reg;
  assign port3_modem_line_select_a = sel_reg[0];
  assign port3_modem_line_select_b = sel_reg[1];
  assign port4_modem_line_select_a = sel_reg[2];
  assign pin_out                   = pin_out_reg;
  assign pin_oe                    = pin_oe_reg;
  assign gpio_in                   = sync2_reg;
  // direction and polarity of the gpio block are software's duty
  assign port3_ring_indicate       = alt_in_reg[0];
  assign port3_carrier_detect      = alt_in_reg[1];
  assign port3_receive_data        = alt_in_reg[2];
  assign port3_set_ready           = alt_in_reg[4];
  assign port3_clear_send          = alt_in_reg[6];
  assign port4_ring_indicate       = alt_in_reg[8];
  assign port4_carrier_detect      = alt_in_reg[9];
  assign port4_receive_data        = alt_in_reg[10];

  // checks
  sequence s_idx_wr(logic [7:0] i);
    data_wr && cfg_mode && idx_reg == i;
  endsequence

  sequence s_idx_rd(logic [7:0] i);
    data_rd && cfg_mode && idx_reg == i;
  endsequence

  AST_RSVD_READ_ZERO: assert property (@(posedge clk) disable iff (rst)
    s_idx_rd(IDX_RSVD) |=> cfg_rvalid && cfg_rdata == 8'h00)
    else $error("reserved slot did not read zero");

  AST_SEL_A_WRITE: assert property (@(posedge clk) disable iff (rst)
    s_idx_wr(IDX_SEL_A) ##1 s_idx_rd(IDX_SEL_A) |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("select a write then read mismatch");

  AST_NO_WRITE_OUTSIDE: assert property (@(posedge clk) disable iff (rst)
    !cfg_mode |=> $stable(port3_modem_line_select_a) && $stable(port3_modem_line_select_b)
                  && $stable(port4_modem_line_select_a))
    else $error("select register changed outside configuration state");

  AST_SEL_B_WRITE: assert property (@(posedge clk) disable iff (rst)
    s_idx_wr(IDX_SEL_B) |=> port3_modem_line_select_b == $past(cfg_wdata)
                            && $stable(port3_modem_line_select_a))
    else $error("select b write lost");

  AST_SEL_C_WRITE: assert property (@(posedge clk) disable iff (rst)
    s_idx_wr(IDX_SEL_C) |=> port4_modem_line_select_a == $past(cfg_wdata)
                            && $stable(port3_modem_line_select_b))
    else $error("port four select write lost");

  AST_RING3_ROUTE: assert property (@(posedge clk) disable iff (rst)
    port3_modem_line_select_a[1:0] == FN_ALT [*2] |-> port3_ring_indicate == $past(sync2_reg[0]))
    else $error("ring indicate not routed from its pin");

  AST_RTS3_DRIVE: assert property (@(posedge clk) disable iff (rst)
    port3_modem_line_select_b[3:2] == FN_ALT |=> pin_oe[5] && pin_out[5] == $past(port3_request_send))
    else $error("request to send not driven on its pin");

  AST_TX4_DRIVE: assert property (@(posedge clk) disable iff (rst)
    port4_modem_line_select_a[7:6] == FN_ALT |=> pin_oe[11] && pin_out[11] == $past(port4_transmit_data))
    else $error("port four transmit not driven on its pin");

  AST_RESET_GPIO: assert property (@(posedge clk)
    $past(rst) |-> port3_modem_line_select_a == 8'h00 && port3_modem_line_select_b == 8'h00
                   && port4_modem_line_select_a == 8'h00)
    else $error("select registers not clear after reset");

  // bit 7 set means code 10 or 11 on the transmit pin: the pad must act as gpio
  AST_RSVD_CODE_GPIO: assert property (@(posedge clk) disable iff (rst)
    port3_modem_line_select_a[7] |=> pin_oe[3] == $past(gpio_oe[3])
                                     && pin_out[3] == $past(gpio_out[3]))
    else $error("reserved code did not fall back to gpio");

  // a receive pin that is not routed must leave the uart input idle
  AST_RX3_IDLE: assert property (@(posedge clk) disable iff (rst)
    port3_modem_line_select_a[5:4] != FN_ALT |=> port3_receive_data == ALT_IDLE)
    else $error("unrouted receive input not idle");

  // register output follows an accepted write on the next edge
  AST_SEL_A_OUT: assert property (@(posedge clk) disable iff (rst)
    s_idx_wr(IDX_SEL_A) |=> port3_modem_line_select_a == $past(cfg_wdata)
                            && $stable(port4_modem_line_select_a))
    else $error("select a write lost");

  // reads return the register content of the taking edge
  AST_SEL_A_READ: assert property (@(posedge clk) disable iff (rst)
    s_idx_rd(IDX_SEL_A) |=> cfg_rvalid && cfg_rdata == $past(port3_modem_line_select_a))
    else $error("select a read returned wrong data");

  // second port three register read path
  AST_SEL_B_READ: assert property (@(posedge clk) disable iff (rst)
    s_idx_rd(IDX_SEL_B) |=> cfg_rvalid && cfg_rdata == $past(port3_modem_line_select_b))
    else $error("select b read returned wrong data");

  // port four register read path
  AST_SEL_C_READ: assert property (@(posedge clk) disable iff (rst)
    s_idx_rd(IDX_SEL_C) |=> cfg_rvalid && cfg_rdata == $past(port4_modem_line_select_a))
    else $error("port four select read returned wrong data");

  // the reserved slot has no storage, so a write there moves nothing
  AST_RSVD_NO_WRITE: assert property (@(posedge clk) disable iff (rst)
    s_idx_wr(IDX_RSVD) |=> $stable(port3_modem_line_select_a)
                           && $stable(port3_modem_line_select_b)
                           && $stable(port4_modem_line_select_a))
    else $error("write to reserved slot changed a select register");

  // no answer strobe without an accepted read
  AST_RVALID_ONLY_READ: assert property (@(posedge clk) disable iff (rst)
    !(data_rd && cfg_mode) |=> !cfg_rvalid)
    else $error("read answer without accepted read");

  // an accepted index write loads the index on the next edge
  AST_INDEX_WRITE: assert property (@(posedge clk) disable iff (rst)
    idx_wr && cfg_mode |=> config_index_register == $past(cfg_wdata))
    else $error("index write lost");

  // transmit of port three drives its pad when routed
  AST_TX3_DRIVE: assert property (@(posedge clk) disable iff (rst)
    port3_modem_line_select_a[7:6] == FN_ALT |=> pin_oe[3]
                                                 && pin_out[3] == $past(port3_transmit_data))
    else $error("port three transmit not driven on its pin");

  // terminal ready of port three drives its pad when routed
  AST_DTR3_DRIVE: assert property (@(posedge clk) disable iff (rst)
    port3_modem_line_select_b[7:6] == FN_ALT |=> pin_oe[7]
                                                 && pin_out[7] == $past(port3_terminal_ready))
    else $error("terminal ready not driven on its pin");

  // clear to send is an input: pad released and level passed through
  AST_CTS3_ROUTE: assert property (@(posedge clk) disable iff (rst)
    port3_modem_line_select_b[5:4] == FN_ALT [*2] |-> !pin_oe[6]
                                                      && port3_clear_send == $past(sync2_reg[6]))
    else $error("clear to send not routed from its pin");

  // receive of port four is an input: pad released and level passed through
  AST_RX4_ROUTE: assert property (@(posedge clk) disable iff (rst)
    port4_modem_line_select_a[5:4] == FN_ALT [*2] |-> !pin_oe[10]
                                                      && port4_receive_data == $past(sync2_reg[10]))
    else $error("port four receive not routed from its pin");

  // a pin not holding the port code stays under gpio control
  AST_GPIO_PIN_FOLLOW: assert property (@(posedge clk) disable iff (rst)
    port4_modem_line_select_a[3:2] != FN_ALT |=> pin_oe[9] == $past(gpio_oe[9])
                                                 && pin_out[9] == $past(gpio_out[9]))
    else $error("gpio pin not following the gpio block");

endmodule // spf_pin_select

// [hdl/spf_pkg.sv]
// constants for the serial port pin function select block
//
// Summary of operation
// - reserved slot 47h reads zero, selects nothing
// - select a: config state and index 48h
// - select a codes route ring, carrier, rx, tx
// - select b: config state and index 49h
// - select b codes route dsr, rts, cts, dtr
// - port four select: config state, index 4Ah
// - port four codes route ring, carrier, rx, tx
// - all select registers clear on standby reset
package spf_pkg;
  // configuration indices
  localparam logic [7:0] IDX_RSVD  = 8'h47;
  localparam logic [7:0] IDX_SEL_A = 8'h48;
  localparam logic [7:0] IDX_SEL_B = 8'h49;
  localparam logic [7:0] IDX_SEL_C = 8'h4A;
  // reset values
  localparam logic [7:0] SEL_RESET  = 8'h00;
  localparam logic [7:0] IDX_RESET  = 8'h00;
  localparam logic [7:0] RSVD_VALUE = 8'h00;
  // field layout: four 2-bit fields per register
  localparam int NUM_REGS   = 3;
  localparam int FIELD_W    = 2;
  localparam int FIELDS_PER = 4;
  localparam int NUM_PINS   = NUM_REGS * FIELDS_PER;
  // field codes
  localparam logic [1:0] FN_GPIO = 2'h0;
  localparam logic [1:0] FN_ALT  = 2'h1;
  // pins whose alternate function is a serial-port output
  // (tx3 on pin 3, rts3 on 5, dtr3 on 7, tx4 on 11)
  localparam logic [11:0] ALT_IS_OUT = 12'h8A8;
  // idle level of an active-low modem input not routed
  localparam logic ALT_IDLE = 1'b1;
endpackage

// [verif/spf_pin_select_test.sv]
// self-checking bench for the serial port pin function select block
`timescale 1ns/1ps
module spf_pin_select_test;
  import spf_pkg::*;
  logic        clk, rst, cfg_mode, idx_wr, data_wr, data_rd;  // clock, reset, access strobes
  logic [7:0]  cfg_wdata, idx_q, rdata, sel_a, sel_b, sel_c;  // access data and registers
  logic        rvalid;                                        // read answer strobe
  logic [11:0] pin_in, pin_out, pin_oe, gpio_out, gpio_oe, gpio_in;  // pad side
  logic        tx3, rts3, dtr3, tx4;                          // uart outputs towards pads
  logic [7:0]  modem;                                         // uart inputs from pads
  int          errors, checks_done, cycles;                   // bookkeeping
  spf_pin_select u_dut (.clk(clk), .rst(rst), .cfg_mode(cfg_mode), .idx_wr(idx_wr),
    .data_wr(data_wr), .data_rd(data_rd), .cfg_wdata(cfg_wdata),
    .config_index_register(idx_q), .cfg_rdata(rdata), .cfg_rvalid(rvalid),
    .port3_modem_line_select_a(sel_a), .port3_modem_line_select_b(sel_b),
    .port4_modem_line_select_a(sel_c), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in), .port3_transmit_data(tx3),
    .port3_request_send(rts3), .port3_terminal_ready(dtr3), .port4_transmit_data(tx4),
    .port3_ring_indicate(modem[7]), .port3_carrier_detect(modem[6]),
    .port3_receive_data(modem[5]), .port3_set_ready(modem[4]), .port3_clear_send(modem[3]),
    .port4_ring_indicate(modem[2]), .port4_carrier_detect(modem[1]),
    .port4_receive_data(modem[0]));
  // free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      results();
    end
  end
  // one comparison; four-state so an unknown never matches
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // index write then data write, each strobe one cycle, driven on falling edges
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] val);
    @(negedge clk); idx_wr = 1'b1; cfg_wdata = idx;
    @(negedge clk); idx_wr = 1'b0; data_wr = 1'b1; cfg_wdata = val;
    @(negedge clk); data_wr = 1'b0;
  endtask
  // index write then data read; answer stands one cycle after the taking edge
  task automatic rd_reg(input logic [7:0] idx, input logic [7:0] exp);
    @(negedge clk); idx_wr = 1'b1; cfg_wdata = idx;
    @(negedge clk); idx_wr = 0; data_rd = 1'b1;
    @(negedge clk); data_rd = 1'b0;
    check("rvalid", {11'h000, rvalid}, 12'h001);
    check("rdata", {4'h0, rdata}, {4'h0, exp});
  endtask
  // drives two pad and uart patterns; alt means every field holds the port code
  task automatic mux_run(input logic alt);
    logic [11:0] e_out;
    for (int p = 0; p < 2; p++) begin
      @(negedge clk);
      pin_in = p ? 12'hA5C : 12'h5A3;
      {tx3, rts3, dtr3, tx4} = p ? 4'hA : 4'h5;
      gpio_out = p ? 12'h3C9 : 12'hC36;
      gpio_oe = p ? 12'hF0F : 12'h0F0; // plays software's direction bits
      repeat (5) @(negedge clk);
      e_out = alt ? {tx4, 3'h0, dtr3, 1'b0, rts3, 1'b0, tx3, 3'h0} : gpio_out;
      check("pin_oe", pin_oe, alt ? ALT_IS_OUT : gpio_oe);
      check("pin_out", pin_out, e_out);
      check("modem", {4'h0, modem}, alt ? {4'h0, pin_in[0], pin_in[1], pin_in[2], pin_in[4],
        pin_in[6], pin_in[8], pin_in[9], pin_in[10]} : 12'h0FF);
      check("gpio_in", gpio_in, pin_in);
    end
  endtask
  // closing report
  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial begin
    errors = 0; checks_done = 0; cycles = 0;
    rst = 1'b1; cfg_mode = 1'b1; idx_wr = 0; data_wr = 0; data_rd = 0; cfg_wdata = 8'h00;
    pin_in = 12'h000; gpio_out = 12'h000; gpio_oe = 12'h000; {tx3, rts3, dtr3, tx4} = 4'h0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    check("index", {4'h0, idx_q}, {4'h0, IDX_RESET});
    check("selects", {sel_a, sel_b[3:0]}, 12'h000);
    check("selects", {sel_b[7:4], sel_c}, 12'h000);
    rd_reg(IDX_SEL_A, SEL_RESET);
    rd_reg(IDX_SEL_B, SEL_RESET);
    rd_reg(IDX_SEL_C, SEL_RESET);
    mux_run(1'b0);
    // reserved slot keeps zero even after a write
    wr_reg(IDX_RSVD, 8'hFF);
    rd_reg(IDX_RSVD, RSVD_VALUE);
    // writes outside configuration state are dropped
    cfg_mode = 1'b0;
    wr_reg(IDX_SEL_A, 8'h55);
    wr_reg(IDX_SEL_C, 8'h55);
    @(negedge clk); cfg_mode = 1'b1;
    check("index", {4'h0, idx_q}, {4'h0, IDX_RSVD});
    rd_reg(IDX_SEL_A, 8'h00);
    rd_reg(IDX_SEL_C, 8'h00);
    // every field to the port code
    wr_reg(IDX_SEL_A, 8'h55);
    wr_reg(IDX_SEL_B, 8'h55);
    wr_reg(IDX_SEL_C, 8'h55);
    rd_reg(IDX_SEL_A, 8'h55);
    rd_reg(IDX_SEL_B, 8'h55);
    rd_reg(IDX_SEL_C, 8'h55);
    check("sel_c", {4'h0, sel_c}, 12'h055);
    check("index", {4'h0, idx_q}, {4'h0, IDX_SEL_C});
    mux_run(1'b1);
    // both reserved codes leave the pins as plain gpio
    for (int k = 0; k < 2; k++) begin
      wr_reg(IDX_SEL_A, k ? 8'hFF : 8'hAA);
      wr_reg(IDX_SEL_B, k ? 8'hFF : 8'hAA);
      wr_reg(IDX_SEL_C, k ? 8'hFF : 8'hAA);
      rd_reg(IDX_SEL_B, k ? 8'hFF : 8'hAA);
      mux_run(1'b0);
    end
    // mid-run reset clears every select back to gpio
    @(negedge clk); rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check("selects", {sel_a, sel_b[3:0]}, 12'h000);
    check("selects", {sel_b[7:4], sel_c}, 12'h000);
    check("pin_oe", pin_oe, 12'h000);
    check("modem", {4'h0, modem}, 12'h0FF);
    results();
  end
endmodule // spf_pin_select_test
